// File: core/ptpc_top.sv
// Target pin control of a programming pod: direction, release and shifting.
`timescale 1ns/100ps
`include "ptpc_consts.svh"
module ptpc_top
  import ptpc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_mode,
  input wire logic cmd_fpga,
  input wire logic cmd_hold_en,
  output logic cmd_ready,
  output logic op_busy,
  input wire logic data_valid,
  input wire logic data_dout,
  input wire logic data_sel,
  input wire logic data_last,
  output logic data_ready,
  input wire logic vref_ok_pin,
  input wire logic vref_full_pin,
  input wire logic [4:0] pin_i,
  output logic [4:0] pin_o,
  output logic [4:0] pin_oe,
  output logic [4:0] pin_level,
  output logic pseudo_ground_line_o,
  output logic pseudo_ground_line_oe
);

  // System-side command state.
  ptpc_mode_t mode_reg, mode_next;
  logic fpga_reg, fpga_next;
  logic hold_reg, hold_next;
  logic busy_reg, busy_next;
  logic ready_reg, ready_next;
  logic start_tgl_reg, start_tgl_next;
  logic done_seen_reg, done_seen_next;
  logic done_s;

  // Link-side state.
  logic link_rst;
  logic start_s, vref_ok_s, vref_full_s;
  ptpc_lstate_t state_reg, state_next;
  ptpc_mode_t mode_l_reg, mode_l_next;
  logic fpga_l_reg, fpga_l_next;
  logic hold_l_reg, hold_l_next;
  logic slow_l_reg, slow_l_next;
  logic start_seen_reg, start_seen_next;
  logic done_tgl_reg, done_tgl_next;
  logic [`PTPC_CNT_W-1:0] cnt_reg, cnt_next, half;
  logic sck_reg, sck_next;
  logic dout_reg, dout_next;
  logic sel_reg, sel_next;
  logic last_reg, last_next;
  logic [4:0] pin_o_reg, pin_o_next;
  logic [4:0] pin_oe_reg, pin_oe_next;
  logic pseudo_ground_line_oe_reg, pseudo_ground_line_oe_next;
  logic [4:0] dir, val;
  logic drive, park;

  // FIFO read side.
  logic fifo_valid, fifo_pop;
  logic [`PTPC_WORD_W-1:0] fifo_word;

  // Pin levels are sampled into the system domain for host status reads.
  genvar gi;
  generate
    for (gi = 0; gi < `PTPC_NPINS; gi++) begin : g_pin_sync
      ptpc_sync u_sync (
        .clk(sys_clk),
        .d(pin_i[gi]),
        .q(pin_level[gi])
      );
    end
  endgenerate

  // Crossings into the link domain: reset, start event and comparators; the done toggle crosses back to the system.
  ptpc_sync u_rst_sync (.clk(link_clk), .d(sys_rst), .q(link_rst));
  ptpc_sync u_start_sync (.clk(link_clk), .d(start_tgl_reg), .q(start_s));
  ptpc_sync u_vok_sync (.clk(link_clk), .d(vref_ok_pin), .q(vref_ok_s));
  ptpc_sync u_vfull_sync (.clk(link_clk), .d(vref_full_pin), .q(vref_full_s));
  ptpc_sync u_done_sync (.clk(sys_clk), .d(done_tgl_reg), .q(done_s));

  // Shift words cross from the host stream to the link; a full FIFO stalls
  // the host through data_ready, an empty one stalls the shift clock.
  ptpc_fifo #(
    .WIDTH(`PTPC_WORD_W),
    .AW(`PTPC_FIFO_AW)
  ) u_fifo (
    .w_clk(sys_clk),
    .w_rst(sys_rst),
    .w_valid(data_valid),
    .w_data({data_last, data_sel, data_dout}),
    .w_ready(data_ready),
    .r_clk(link_clk),
    .r_rst(link_rst),
    .r_valid(fifo_valid),
    .r_data(fifo_word),
    .r_ready(fifo_pop)
  );

  // Command acceptance; configuration stays frozen while busy so the link
  // can read it once the start toggle has crossed.
  always_comb begin
    mode_next = mode_reg;
    fpga_next = fpga_reg;
    hold_next = hold_reg;
    busy_next = busy_reg;
    start_tgl_next = start_tgl_reg;
    done_seen_next = done_seen_reg;
    if (!busy_reg && cmd_valid) begin
      mode_next = ptpc_mode_t'(cmd_mode);
      fpga_next = cmd_fpga;
      hold_next = cmd_hold_en;
      busy_next = 1'b1;
      start_tgl_next = !start_tgl_reg;
    end else if (busy_reg && (done_s != done_seen_reg)) begin
      busy_next = 1'b0;
      done_seen_next = done_s;
    end
    ready_next = !busy_next;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mode_reg <= PTPC_MODE_JTAG;
      fpga_reg <= 1'b0;
      hold_reg <= 1'b0;
      busy_reg <= 1'b0;
      ready_reg <= 1'b1;
      start_tgl_reg <= 1'b0;
      done_seen_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      fpga_reg <= fpga_next;
      hold_reg <= hold_next;
      busy_reg <= busy_next;
      ready_reg <= ready_next;
      start_tgl_reg <= start_tgl_next;
      done_seen_reg <= done_seen_next;
    end
  end

  // Sequencer: latch mode, shift words, park outputs high, then release.
  always_comb begin
    state_next = state_reg;
    mode_l_next = mode_l_reg;
    fpga_l_next = fpga_l_reg;
    hold_l_next = hold_l_reg;
    slow_l_next = slow_l_reg;
    start_seen_next = start_seen_reg;
    done_tgl_next = done_tgl_reg;
    cnt_next = cnt_reg;
    sck_next = sck_reg;
    dout_next = dout_reg;
    sel_next = sel_reg;
    last_next = last_reg;
    fifo_pop = 1'b0;
    half = slow_l_reg ? `PTPC_CNT_W'(`PTPC_HALF_SLOW - 1) :
                        `PTPC_CNT_W'(`PTPC_HALF_FAST - 1);
    unique case (state_reg)
      PTPC_L_IDLE: begin
        if (start_s != start_seen_reg) begin
          start_seen_next = start_s;
          mode_l_next = mode_reg;
          fpga_l_next = fpga_reg;
          hold_l_next = hold_reg;
          slow_l_next = !vref_full_s;
          state_next = PTPC_L_SHIFT;
          sck_next = 1'b1;
          cnt_next = '0;
          last_next = 1'b0;
        end
      end
      PTPC_L_SHIFT: begin
        if (cnt_reg != '0) begin
          cnt_next = cnt_reg - 1'b1;
        end else if (sck_reg) begin
          if (last_reg) begin
            state_next = PTPC_L_PARK;
            cnt_next = `PTPC_CNT_W'(`PTPC_PARK_CYCLES - 1);
          end else if (fifo_valid) begin
            // New data leave together with the falling edge.
            fifo_pop = 1'b1;
            dout_next = fifo_word[0];
            sel_next = fifo_word[1];
            last_next = fifo_word[2];
            sck_next = 1'b0;
            cnt_next = half;
          end
        end else begin
          sck_next = 1'b1;
          cnt_next = half;
        end
      end
      PTPC_L_PARK: begin
        if (cnt_reg != '0) begin
          cnt_next = cnt_reg - 1'b1;
        end else begin
          state_next = PTPC_L_IDLE;
          done_tgl_next = !done_tgl_reg;
        end
      end
      default: begin
        state_next = PTPC_L_IDLE;
      end
    endcase
  end

  // Pin drivers follow the next state so each output is a plain flop.
  always_comb begin
    drive = (state_next != PTPC_L_IDLE) && vref_ok_s;
    park = state_next == PTPC_L_PARK;
    unique case (mode_l_next)
      PTPC_MODE_SPI: dir = `PTPC_DIR_SPI;
      PTPC_MODE_SSER: dir = `PTPC_DIR_SSER;
      default: dir = `PTPC_DIR_JTAG |
                     (hold_l_next ? `PTPC_DIR_HOLD : `PTPC_PIN_RST);
    endcase
    val = `PTPC_PIN_ALL_HIGH;
    val[`PTPC_PIN_DATA_OUT] = dout_next;
    val[`PTPC_TARGET_SHIFT_CLOCK] = sck_next;
    val[`PTPC_TARGET_MODE_SELECT_LINE] = sel_next;
    val[`PTPC_PIN_HOLD] = !fpga_l_next;
    pin_oe_next = drive ? dir : `PTPC_PIN_RST;
    pin_o_next = park ? `PTPC_PIN_ALL_HIGH : val;
    // Pseudo ground stays low through the park phase; it is open drain so
    // releasing it needs no high drive first.
    pseudo_ground_line_oe_next = drive;
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      state_reg <= PTPC_L_IDLE;
      mode_l_reg <= PTPC_MODE_JTAG;
      fpga_l_reg <= 1'b0;
      hold_l_reg <= 1'b0;
      slow_l_reg <= 1'b0;
      start_seen_reg <= 1'b0;
      done_tgl_reg <= 1'b0;
      cnt_reg <= '0;
      sck_reg <= 1'b1;
      dout_reg <= 1'b1;
      sel_reg <= 1'b1;
      last_reg <= 1'b0;
      pin_o_reg <= `PTPC_PIN_ALL_HIGH;
      pin_oe_reg <= `PTPC_PIN_RST;
      pseudo_ground_line_oe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      mode_l_reg <= mode_l_next;
      fpga_l_reg <= fpga_l_next;
      hold_l_reg <= hold_l_next;
      slow_l_reg <= slow_l_next;
      start_seen_reg <= start_seen_next;
      done_tgl_reg <= done_tgl_next;
      cnt_reg <= cnt_next;
      sck_reg <= sck_next;
      dout_reg <= dout_next;
      sel_reg <= sel_next;
      last_reg <= last_next;
      pin_o_reg <= pin_o_next;
      pin_oe_reg <= pin_oe_next;
      pseudo_ground_line_oe_reg <= pseudo_ground_line_oe_next;
    end
  end

  assign cmd_ready = ready_reg;
  assign op_busy = busy_reg;
  assign pin_o = pin_o_reg;
  assign pin_oe = pin_oe_reg;
  assign pseudo_ground_line_o = 1'b0;
  assign pseudo_ground_line_oe = pseudo_ground_line_oe_reg;

  // Checks on the link-side drivers and sequencer, and on command acceptance.
  vref_hiz_a: assert property (
    @(posedge link_clk) disable iff (link_rst)
    !vref_ok_s |=> (pin_oe_reg == `PTPC_PIN_RST) && !pseudo_ground_line_oe_reg)
    else $error("drivers enabled with low reference");
  idle_hiz_a: assert property (
    @(posedge link_clk) disable iff (link_rst)
    (state_reg == PTPC_L_IDLE) |->
    (pin_oe_reg == `PTPC_PIN_RST) && !pseudo_ground_line_oe_reg)
    else $error("drivers enabled while idle");
  park_high_a: assert property (
    @(posedge link_clk) disable iff (link_rst)
    (state_reg == PTPC_L_SHIFT) ##1 (state_reg == PTPC_L_PARK) ##1
    (state_reg == PTPC_L_IDLE) |-> $past(pin_o_reg) == `PTPC_PIN_ALL_HIGH)
    else $error("output released without driving high");
  shift_dir_a: assert property (
    @(posedge link_clk) disable iff (link_rst)
    (state_reg == PTPC_L_SHIFT) && $past(vref_ok_s) |->
    pin_oe_reg[`PTPC_TARGET_SHIFT_CLOCK] && !pin_oe_reg[`PTPC_PIN_DATA_IN])
    else $error("pin direction wrong during shift");
  pseudo_ground_line_low_a: assert property (
    @(posedge link_clk) disable iff (link_rst)
    (state_reg != PTPC_L_IDLE) && $past(vref_ok_s) |-> pseudo_ground_line_oe_reg)
    else $error("pseudo ground not pulled during operation");
  hold_fpga_a: assert property (
    @(posedge link_clk) disable iff (link_rst)
    (state_reg == PTPC_L_SHIFT) && (mode_l_reg == PTPC_MODE_JTAG) &&
    hold_l_reg && fpga_l_reg && $past(vref_ok_s) |->
    pin_oe_reg[`PTPC_PIN_HOLD] && !pin_o_reg[`PTPC_PIN_HOLD])
    else $error("hold not low for fpga target");
  hold_other_a: assert property (
    @(posedge link_clk) disable iff (link_rst)
    (state_reg == PTPC_L_SHIFT) && (mode_l_reg == PTPC_MODE_JTAG) &&
    hold_l_reg && !fpga_l_reg && $past(vref_ok_s) |->
    pin_oe_reg[`PTPC_PIN_HOLD] && pin_o_reg[`PTPC_PIN_HOLD])
    else $error("hold not high for other target");
  hold_off_a: assert property (
    @(posedge link_clk) disable iff (link_rst)
    // Mode code 3 is decoded as JTAG, so only SPI and slave serial count.
    !hold_l_reg || (mode_l_reg == PTPC_MODE_SPI) ||
    (mode_l_reg == PTPC_MODE_SSER) |->
    !pin_oe_reg[`PTPC_PIN_HOLD])
    else $error("hold driven while disabled");
  data_fall_a: assert property (
    @(posedge link_clk) disable iff (link_rst)
    (state_reg == PTPC_L_SHIFT) && ($past(state_reg) == PTPC_L_SHIFT) &&
    ($changed(pin_o_reg[`PTPC_PIN_DATA_OUT]) ||
     $changed(pin_o_reg[`PTPC_TARGET_MODE_SELECT_LINE])) |->
    $fell(pin_o_reg[`PTPC_TARGET_SHIFT_CLOCK]))
    else $error("data changed off a falling clock edge");
  slow_low_a: assert property (
    @(posedge link_clk) disable iff (link_rst)
    slow_l_reg && (state_reg == PTPC_L_SHIFT) && $fell(sck_reg) |->
    (!sck_reg)[*3])
    else $error("slow shift clock low phase too short");
  mode_hold_a: assert property (
    @(posedge link_clk) disable iff (link_rst)
    (state_reg != PTPC_L_IDLE) && ($past(state_reg) != PTPC_L_IDLE) |->
    $stable(mode_l_reg) && $stable(hold_l_reg))
    else $error("mode changed during operation");
  busy_ready_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    cmd_valid && cmd_ready |=> op_busy && !cmd_ready &&
    (mode_reg == $past(cmd_mode)))
    else $error("command not latched on acceptance");

  // Main scenarios.
  jtag_op_c: cover property (@(posedge link_clk) disable iff (link_rst)
    (state_reg == PTPC_L_PARK) && (mode_l_reg == PTPC_MODE_JTAG) &&
    hold_l_reg);
  spi_op_c: cover property (@(posedge link_clk) disable iff (link_rst)
    (state_reg == PTPC_L_PARK) && (mode_l_reg == PTPC_MODE_SPI));
  vref_drop_c: cover property (@(posedge link_clk) disable iff (link_rst)
    (state_reg == PTPC_L_SHIFT) && !vref_ok_s);
  fifo_full_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    data_valid && !data_ready);

endmodule

// File: common/ptpc_consts.svh
// Constants for the programmer target pin control block.
`ifndef PTPC_CONSTS_SVH
`define PTPC_CONSTS_SVH

// Target pin indices within the five-bit pin vectors.
`define PTPC_PIN_DATA_OUT 0
`define PTPC_PIN_DATA_IN 1
`define PTPC_TARGET_SHIFT_CLOCK 2
`define PTPC_TARGET_MODE_SELECT_LINE 3
`define PTPC_PIN_HOLD 4
`define PTPC_NPINS 5

// Reset values of the pin drivers: all released.
`define PTPC_PIN_RST 5'h00
`define PTPC_PIN_ALL_HIGH 5'h1f

// Direction masks per mode; a set bit drives the pin.
`define PTPC_DIR_JTAG 5'h0d
`define PTPC_DIR_SPI 5'h0d
`define PTPC_DIR_SSER 5'h0d
`define PTPC_DIR_HOLD 5'h10

// Analog thresholds of the external reference comparators, in mV.
`define PTPC_VREF_MIN_MV 1300
`define PTPC_VREF_FULL_MV 3300

// Shift clock timing, derived from the link clock period.
`define PTPC_LINK_PERIOD_PS 30000
`define PTPC_SCK_MAX_MHZ 24
`define PTPC_SCK_HALF_PS (1000000 / (2 * `PTPC_SCK_MAX_MHZ))
`define PTPC_HALF_FAST ((`PTPC_SCK_HALF_PS + `PTPC_LINK_PERIOD_PS - 1) / `PTPC_LINK_PERIOD_PS)
`define PTPC_SLOW_FACTOR 3
`define PTPC_HALF_SLOW (`PTPC_HALF_FAST * `PTPC_SLOW_FACTOR)
`define PTPC_PARK_CYCLES 1
`define PTPC_CNT_W 2

// Data FIFO shape: word is {last, mode select, data out}.
`define PTPC_WORD_W 3
`define PTPC_FIFO_AW 3

`endif

// File: common/ptpc_pkg.sv
// Types shared by the programmer target pin control block.
package ptpc_pkg;

  // Target protocol selected by the host command.
  typedef enum logic [1:0] {
    PTPC_MODE_JTAG = 2'h0,
    PTPC_MODE_SPI = 2'h1,
    PTPC_MODE_SSER = 2'h2
  } ptpc_mode_t;

  // Link-side sequencer states, one-hot.
  typedef enum logic [2:0] {
    PTPC_L_IDLE = 3'h1,
    PTPC_L_SHIFT = 3'h2,
    PTPC_L_PARK = 3'h4
  } ptpc_lstate_t;

endpackage

// File: core/ptpc_sync.sv
// Two-flop synchroniser for one level crossing into a clock domain.
`timescale 1ns/100ps
module ptpc_sync (
  input wire logic clk,
  input wire logic d,
  output logic q
);

  logic meta_reg;
  logic q_reg;

  // The first stage feeds only the second; no reset so it can carry resets.
  always_ff @(posedge clk) begin
    meta_reg <= d;
    q_reg <= meta_reg;
  end

  assign q = q_reg;

endmodule

// File: core/ptpc_fifo.sv
// Dual-clock FIFO with gray-coded pointers and registered full and empty.
`timescale 1ns/100ps
module ptpc_fifo #(
  parameter int WIDTH = 3,
  parameter int AW = 3
) (
  input wire logic w_clk,
  input wire logic w_rst,
  input wire logic w_valid,
  input wire logic [WIDTH-1:0] w_data,
  output logic w_ready,
  input wire logic r_clk,
  input wire logic r_rst,
  output logic r_valid,
  output logic [WIDTH-1:0] r_data,
  input wire logic r_ready
);

  logic [WIDTH-1:0] mem_reg [0:(1<<AW)-1];
  logic [AW:0] wbin_reg, wbin_next, wgray_reg, wgray_next;
  logic [AW:0] rbin_reg, rbin_next, rgray_reg, rgray_next;
  logic [AW:0] rq1_reg, rq2_reg, wq1_reg, wq2_reg;
  logic full_reg, full_next, empty_reg, empty_next;
  logic push, pop;

  // Write side: full is judged on the next pointer so it is registered.
  always_comb begin
    push = w_valid && !full_reg;
    wbin_next = wbin_reg + (AW+1)'(push);
    wgray_next = (wbin_next >> 1) ^ wbin_next;
    full_next = wgray_next == {~rq2_reg[AW:AW-1], rq2_reg[AW-2:0]};
  end

  always_ff @(posedge w_clk) begin
    if (w_rst) begin
      wbin_reg <= '0;
      wgray_reg <= '0;
      full_reg <= 1'b1;
    end else begin
      wbin_reg <= wbin_next;
      wgray_reg <= wgray_next;
      full_reg <= full_next;
    end
    rq1_reg <= rgray_reg;
    rq2_reg <= rq1_reg;
    if (push) begin
      mem_reg[wbin_reg[AW-1:0]] <= w_data;
    end
  end

  // Read side: empty comes from the synchronised write pointer.
  always_comb begin
    pop = r_ready && !empty_reg;
    rbin_next = rbin_reg + (AW+1)'(pop);
    rgray_next = (rbin_next >> 1) ^ rbin_next;
    empty_next = rgray_next == wq2_reg;
  end

  always_ff @(posedge r_clk) begin
    if (r_rst) begin
      rbin_reg <= '0;
      rgray_reg <= '0;
      empty_reg <= 1'b1;
    end else begin
      rbin_reg <= rbin_next;
      rgray_reg <= rgray_next;
      empty_reg <= empty_next;
    end
    wq1_reg <= wgray_reg;
    wq2_reg <= wq1_reg;
  end

  assign w_ready = !full_reg;
  assign r_valid = !empty_reg;
  assign r_data = mem_reg[rbin_reg[AW-1:0]];

endmodule

// File: tb/ptpc_target_model.sv
// Behavioural target: weak pull-ups on the lines and a sampling shifter.
`timescale 1ns/100ps
module ptpc_target_model (
  input wire logic [4:0] pin_o,
  input wire logic [4:0] pin_oe,
  output logic [4:0] pin_i,
  output logic [4:0] lvl
);
  logic [31:0] cap_d;
  logic [31:0] cap_s;
  logic ret_bit;
  int cnt;
  int min_per;
  realtime last_t;

  // A released line floats up through its pull-up, never holds its value.
  assign lvl = (pin_oe & pin_o) | ~pin_oe;
  assign pin_i = {lvl[4:2], ret_bit, lvl[0]};

  // Forget what was seen, so each operation is judged on its own.
  task clear;
    cap_d = 0;
    cap_s = 0;
    cnt = 0;
    min_per = 1000000;
    last_t = 0;
  endtask

  initial begin
    ret_bit = 1'b0;
    clear();
  end

  // The target samples data and select on the rising clock edge.
  always @(posedge lvl[2]) begin
    if (pin_oe[2] === 1'b1) begin
      if (cnt > 0 && int'($realtime - last_t) < min_per) begin
        min_per = int'($realtime - last_t);
      end
      last_t = $realtime;
      cap_d = {cap_d[30:0], lvl[0]};
      cap_s = {cap_s[30:0], lvl[3]};
      cnt++;
    end
  end

  // The returned data line moves on the falling edge, as a chain would.
  always @(negedge lvl[2]) begin
    ret_bit = ~ret_bit;
  end
endmodule

// File: tb/programmer_target_pin_control_tb_top.sv
// Self-checking bench for the target pin control block.
`timescale 1ns/100ps
module programmer_target_pin_control_tb_top;
  import ptpc_pkg::*;
  logic sys_clk = 0;
  logic link_clk = 0;
  logic sys_rst, cmd_valid, cmd_fpga, cmd_hold_en, data_valid;
  logic data_dout, data_sel, data_last, vref_ok_pin, vref_full_pin;
  logic cmd_ready, op_busy, data_ready, gnd_o, gnd_oe, r4_en;
  logic [1:0] cmd_mode;
  logic [4:0] pin_i, pin_o, pin_oe, pin_level, prev_oe, prev_o;
  logic [7:0] wd, ws;
  int fails = 0;
  int checked = 0;

  initial forever #2.5 sys_clk = ~sys_clk;
  // The link clock starts off phase so no edge lines up with the system.
  initial begin
    #7;
    forever #15 link_clk = ~link_clk;
  end

  ptpc_top i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .link_clk(link_clk), .cmd_valid(cmd_valid), .cmd_mode(cmd_mode),
    .cmd_fpga(cmd_fpga), .cmd_hold_en(cmd_hold_en),
    .cmd_ready(cmd_ready), .op_busy(op_busy), .data_valid(data_valid),
    .data_dout(data_dout), .data_sel(data_sel), .data_last(data_last),
    .data_ready(data_ready), .vref_ok_pin(vref_ok_pin),
    .vref_full_pin(vref_full_pin), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe(pin_oe), .pin_level(pin_level),
    .pseudo_ground_line_o(gnd_o), .pseudo_ground_line_oe(gnd_oe));

  ptpc_target_model i_tgt (.pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i),
    .lvl());

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Levels the bounded wait can watch, picked by code.
  localparam int W_DRDY = 0;
  localparam int W_CRDY = 1;
  localparam int W_GND = 2;
  localparam int W_BUSY = 3;

  function automatic logic pick(input int sel);
    pick = (sel == W_DRDY) ? data_ready : (sel == W_CRDY) ? cmd_ready :
           (sel == W_GND) ? gnd_oe : op_busy;
  endfunction

  // Bounded wait for a level; running out ends the run as a failure.
  task automatic await(input int sel, input logic val);
    int n;
    n = 0;
    while (pick(sel) !== val) begin
      if (n == 4000) begin
        fails++;
        give_verdict();
      end
      n++;
      @(negedge sys_clk);
    end
  endtask

  // Pins 0, 2 and 3 drive in every mode; hold only in JTAG when enabled.
  function automatic logic [4:0] exp_oe(input logic [1:0] m, input logic h);
    exp_oe = 5'h0d;
    if (h && m != PTPC_MODE_SPI && m != PTPC_MODE_SSER) begin
      exp_oe |= 5'h10;
    end
  endfunction

  task automatic push(input logic d, input logic s, input logic l);
    @(negedge sys_clk);
    data_valid = 1;
    data_dout = d;
    data_sel = s;
    data_last = l;
    await(W_DRDY, 1);
    @(negedge sys_clk);
    data_valid = 0;
  endtask

  // A pin that stops driving must have been driven high just before.
  always @(negedge link_clk) begin
    if (r4_en && |(prev_oe & ~pin_oe)) begin
      check(prev_oe & ~pin_oe & ~prev_o, 0);
    end
    prev_oe <= pin_oe;
    prev_o <= pin_o;
  end

  task automatic run_op(input logic [1:0] m, input logic f, input logic h,
      input int nw, input logic slow, input logic drop);
    int pre;
    logic [31:0] ed, es;
    logic [4:0] eo;
    pre = (nw == 8) ? 8 : nw / 2;
    ed = 0;
    es = 0;
    eo = exp_oe(m, h);
    i_tgt.clear();
    r4_en = ~drop;
    vref_full_pin = ~slow;
    {wd, ws} = 16'($urandom);
    for (int k = 0; k < nw; k++) begin
      ed = {ed[30:0], wd[k]};
      es = {es[30:0], ws[k]};
    end
    for (int k = 0; k < pre; k++) push(wd[k], ws[k], k == nw - 1);
    // A full queue refuses a ninth word, so it must never be shifted.
    if (nw == 8) begin
      repeat (2) @(negedge sys_clk);
      check(data_ready, 0);
      data_valid = 1;
      repeat (3) @(negedge sys_clk);
      data_valid = 0;
    end
    await(W_CRDY, 1);
    cmd_valid = 1;
    cmd_mode = m;
    cmd_fpga = f;
    cmd_hold_en = h;
    @(negedge sys_clk);
    cmd_valid = 0;
    {cmd_mode, cmd_fpga, cmd_hold_en} = 4'($urandom);
    check(op_busy, 1);
    for (int k = pre; k < nw; k++) push(wd[k], ws[k], k == nw - 1);
    await(W_GND, 1);
    @(negedge link_clk);
    check(pin_oe, eo);
    check(gnd_oe, 1);
    check(gnd_o, 0);
    // A logical not keeps the expected hold level one bit wide.
    if (eo[4]) check(pin_o[4], !f);
    if (drop) begin
      @(negedge sys_clk);
      vref_ok_pin = 0;
      repeat (4) @(negedge link_clk);
      check({pin_oe, gnd_oe}, 0);
      check(op_busy, 1);
    end
    await(W_BUSY, 0);
    check({pin_oe, gnd_oe}, 0);
    if (!drop) begin
      check(i_tgt.cnt, nw);
      check(i_tgt.cap_d, ed);
      check(i_tgt.cap_s, es);
      check(i_tgt.min_per >= (slow ? 170 : 42), 1);
    end
    vref_ok_pin = 1;
    repeat (4) @(negedge link_clk);
    @(negedge sys_clk);
  endtask

  initial begin
    sys_rst = 1;
    {cmd_valid, cmd_mode, cmd_fpga, cmd_hold_en} = 0;
    {data_valid, data_dout, data_sel, data_last} = 0;
    {vref_ok_pin, vref_full_pin, r4_en} = 3'h6;
    void'($urandom(32'h048b));
    repeat (8) @(negedge sys_clk);
    // The link side takes its reset through flops of its own clock.
    repeat (4) @(negedge link_clk);
    @(negedge sys_clk);
    check({cmd_ready, op_busy}, 2'h2);
    check({pin_oe, gnd_oe}, 0);
    sys_rst = 0;
    repeat (30) @(negedge sys_clk);
    check(pin_level, pin_i);
    for (int m = 0; m < 4; m++) begin
      for (int fh = 0; fh < 4; fh++) begin
        run_op(2'(m), fh[1], fh[0], $urandom_range(8, 1), 1'($urandom), 0);
      end
    end
    run_op(PTPC_MODE_JTAG, 1, 1, 8, 0, 0);
    run_op(PTPC_MODE_SPI, 0, 1, 8, 1, 1);
    give_verdict();
  end
endmodule
